// ---- layout_query_if.sv ----
/*
  Carrier between the lookup top and the bit-slice calculator.
  Assumes both ends sit on the same clock; the carrier is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface layout_query_if;
  import tcam_layout_pkg::*;
  logic is_ing2;
  logic [2:0] size_lg;
  logic [3:0] offset;
  logic legal;
  logic [2:0] tag_w;
  logic [4:0] tag_v;
  logic [BIT_W-1:0] e_lo;
  logic [BIT_W-1:0] e_hi;
  logic act_used;
  logic [BIT_W-1:0] a_lo;
  logic [BIT_W-1:0] a_hi;
  modport ask (output is_ing2, size_lg, offset,
               input legal, tag_w, tag_v, e_lo, e_hi, act_used, a_lo, a_hi);
  modport calc (input is_ing2, size_lg, offset,
                output legal, tag_w, tag_v, e_lo, e_hi, act_used, a_lo, a_hi);
endinterface
`default_nettype wire

// ---- rule_slice_map.sv ----
/*
  Combinational bit-slice calculator: for an engine, rule size and address
  offset, gives the entry tag and the entry/action bit ranges held there.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module rule_slice_map
  import tcam_layout_pkg::*;
(
  layout_query_if.calc q
);

  function automatic logic [2:0] tag_width(input logic ing2, input logic act,
                                           input logic [2:0] lg, input logic [3:0] off);
    logic [2:0] lvl;
    lvl = lg;
    if (off != 4'h0) begin
      if (off[0]) lvl = 3'd0;
      else if (off[1]) lvl = 3'd1;
      else if (off[2]) lvl = 3'd2;
      else lvl = 3'd3;
    end
    if (ing2) begin
      if (act) tag_width = 3'd0;
      else if (lvl >= 3'd2) tag_width = lvl - 3'd1;
      else tag_width = 3'd0;
    end else begin
      tag_width = lvl + 3'd1;
    end
  endfunction

  logic [2:0] act_lg;
  logic [BIT_W-1:0] e_acc;
  logic [BIT_W-1:0] a_acc;
  logic [BIT_W-1:0] e_now;
  logic [BIT_W-1:0] a_now;

  always_comb begin
    // Action never wider than four addresses, even under a wider entry
    act_lg = (q.size_lg > LG_X4) ? LG_X4 : q.size_lg;
    e_acc = '0;
    a_acc = '0;
    for (int k = 0; k < MAX_OFFSETS; k++) begin
      if (4'(k) < q.offset) begin
        e_acc = e_acc + BIT_W'(ENTRY_BITS - 6'(tag_width(q.is_ing2, 1'b0, q.size_lg, 4'(k))));
        a_acc = a_acc + BIT_W'(ACTION_BITS - 7'(tag_width(q.is_ing2, 1'b1, act_lg, 4'(k))));
      end
    end
    q.tag_w = tag_width(q.is_ing2, 1'b0, q.size_lg, q.offset);
    q.tag_v = (q.offset == 4'h0) ? 5'(5'h01 << (q.tag_w - 3'd1)) : 5'h00;
    e_now = BIT_W'(ENTRY_BITS - 6'(q.tag_w));
    a_now = BIT_W'(ACTION_BITS - 7'(tag_width(q.is_ing2, 1'b1, act_lg, q.offset)));
    q.e_lo = e_acc;
    q.e_hi = e_acc + e_now - BIT_W'(1);
    q.act_used = ({1'b0, q.offset} < (5'h01 << act_lg));
    q.a_lo = q.act_used ? a_acc : '0;
    q.a_hi = q.act_used ? (a_acc + a_now - BIT_W'(1)) : '0;
    q.legal = (q.size_lg <= LG_X16) && ({1'b0, q.offset} < (5'h01 << q.size_lg))
              && (!q.is_ing2 || q.size_lg >= LG_X4);
  end

endmodule
`default_nettype wire

// ---- tb_tcam_rule_layout_default_hit.sv ----
/* Self-checking bench: table of keys, layout queries, resets.
   Assumes the design answers one cycle after each request. */
`timescale 1ns/1ps
`default_nettype none
module tb_tcam_rule_layout_default_hit;
  import tcam_layout_pkg::*;
  typedef struct packed {
    logic [1:0] eng; logic [6:0] idx; logic [3:0] blk; logic hit;
    logic [15:0] maddr; logic def; logic err; logic [15:0] addr;
  } row_s;
  row_s rows [8];
  logic clk = 0, rst_b = 0, kv = 0, hit = 0, mreq = 0, ming = 0;
  logic [1:0] eng = 0;
  logic [6:0] idx = 0;
  logic [3:0] blk = 0, moff = 0;
  logic [2:0] mlg = 0;
  logic [15:0] maddr = 0;
  logic r_v, r_d, r_e, c_i, m_a, m_l, m_u;
  logic [15:0] r_a, c_a;
  logic [2:0] m_tw;
  logic [4:0] m_tv;
  logic [9:0] m_el, m_eh, m_al, m_ah;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  tcam_rule_layout_default_hit uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_key_valid(kv),
    .i_key_engine(eng), .i_key_default_idx(idx), .i_key_blocks(blk), .i_match_hit(hit),
    .i_match_addr(maddr), .i_map_req(mreq), .i_map_ing2(ming), .i_map_size_lg(mlg),
    .i_map_offset(moff), .o_res_valid(r_v), .o_res_default(r_d), .o_res_idx_err(r_e),
    .o_res_addr(r_a), .o_cnt_inc(c_i), .o_cnt_addr(c_a), .o_map_ack(m_a), .o_map_legal(m_l),
    .o_map_tag_w(m_tw), .o_map_tag_v(m_tv), .o_map_e_lo(m_el), .o_map_e_hi(m_eh),
    .o_map_act_used(m_u), .o_map_a_lo(m_al), .o_map_a_hi(m_ah));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic step; @(posedge clk); #1; endtask
  // Array answers only for aligned, fully written rules with clear tag masks
  task automatic drv(input row_s r);
    kv = 1; eng = r.eng; idx = r.idx; blk = r.blk; hit = r.hit; maddr = r.maddr;
  endtask
  // Strobe stays high across calls, so back-to-back queries never drop and raise it at once
  task automatic mq(input logic g, input logic [2:0] l, input logic [3:0] o);
    mreq = 1; ming = g; mlg = l; moff = o;
    step;
    chk(m_a, 1);
  endtask
  task automatic mchk(input logic [9:0] el, eh, input logic u, input logic [9:0] al, ah);
    chk(m_l, 1); chk(m_el, el); chk(m_eh, eh); chk(m_u, u); chk(m_al, al); chk(m_ah, ah);
  endtask
  // Timeout ceiling far above the roughly fifty cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    rows = '{'{2'h0, 7'h00, 4'h0, 1'b1, 16'h0104, 1'b1, 1'b0, 16'h8000},
             '{2'h0, 7'h71, 4'h1, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h8710},
             '{2'h1, 7'h02, 4'h0, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h8740},
             '{2'h2, 7'h05, 4'h0, 1'b1, 16'h0200, 1'b1, 1'b0, 16'h8E90},
             '{2'h3, 7'h39, 4'h2, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h98F0},
             '{2'h3, 7'h00, 4'h3, 1'b1, 16'h1104, 1'b0, 1'b0, 16'h1104},
             '{2'h3, 7'h3A, 4'h1, 1'b0, 16'h0000, 1'b1, 1'b1, 16'h9560},
             '{2'h0, 7'h72, 4'h1, 1'b0, 16'h0000, 1'b1, 1'b1, 16'h8000}};
    repeat (16) step;
    rst_b = 1;
    chk(r_v, 0); chk(r_a, 0); chk(m_a, 0);
    step;
    foreach (rows[i]) begin
      drv(rows[i]);
      step;
      kv = 0;
      chk(r_v, 1); chk(r_d, rows[i].def); chk(r_e, rows[i].err);
      chk(r_a, rows[i].addr); chk(c_i, 1); chk(c_a, rows[i].addr);
      step;
      chk(r_v, 0); chk(r_a, rows[i].addr);
    end
    // Back to back keys, no idle cycle between
    drv(rows[2]);
    step;
    drv(rows[5]);
    chk(r_a, 16'h8740);
    step;
    kv = 0;
    chk(r_v, 1); chk(r_a, 16'h1104); chk(c_a, 16'h1104);
    mq(0, 3'h4, 4'hF); chk(m_tw, 1); mchk(510, 544, 0, 0, 0);
    mq(0, 3'h0, 4'h0); chk(m_tw, 1); mchk(0, 34, 1, 0, 68);
    mq(1, 3'h4, 4'hF); chk(m_tw, 0); mchk(533, 568, 0, 0, 0);
    mq(1, 3'h2, 4'h0); chk(m_tv, 1); mchk(0, 34, 1, 0, 69);
    mq(1, 3'h2, 4'h3); mchk(107, 142, 1, 210, 279);
    mq(1, 3'h0, 4'h0); chk(m_l, 0);
    mq(0, 3'h2, 4'h0); chk(m_tw, 3); chk(m_tv, 4); mchk(0, 32, 1, 0, 66);
    mq(0, 3'h2, 4'h2); chk(m_tw, 2); chk(m_tv, 0); mchk(68, 101, 1, 136, 203);
    mq(0, 3'h1, 4'h1); chk(m_tw, 1); mchk(34, 68, 1, 68, 136);
    mq(1, 3'h4, 4'h0); chk(m_tw, 3); chk(m_tv, 4); mchk(0, 32, 1, 0, 69);
    mq(1, 3'h3, 4'h0); chk(m_tw, 2); chk(m_tv, 2); mchk(0, 33, 1, 0, 69);
    mq(1, 3'h3, 4'h4); chk(m_tw, 1); chk(m_tv, 0); mchk(142, 176, 0, 0, 0);
    mq(1, 3'h4, 4'h8); chk(m_tw, 2); chk(m_tv, 0); mchk(284, 317, 0, 0, 0);
    mq(0, 3'h5, 4'h0); chk(m_l, 0);
    mreq = 0;
    step;
    chk(m_a, 0);
    rst_b = 0;
    step;
    rst_b = 1;
    chk(r_a, 0); chk(c_a, 0); chk(m_l, 0);
    step;
    drv(rows[3]);
    step;
    kv = 0;
    chk(r_v, 1); chk(r_d, 1); chk(r_a, 16'h8E90);
    stop_test;
  end
endmodule
bind tcam_rule_layout_default_hit tcam_layout_chk chk_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_key_valid(i_key_valid), .i_key_engine(i_key_engine), .i_key_default_idx(i_key_default_idx),
  .i_key_blocks(i_key_blocks), .i_match_hit(i_match_hit), .i_match_addr(i_match_addr),
  .i_map_req(i_map_req), .o_res_valid(o_res_valid), .o_res_default(o_res_default),
  .o_res_addr(o_res_addr), .o_cnt_inc(o_cnt_inc), .o_cnt_addr(o_cnt_addr), .o_map_ack(o_map_ack));
`default_nettype wire

// ---- tcam_layout_chk.sv ----
/* Port checker for the lookup resolver and layout query.
   Assumes it is bound to the top module on one clock. */
`timescale 1ns/1ps
`default_nettype none
module tcam_layout_chk
  import tcam_layout_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_key_valid,
  input wire logic [1:0] i_key_engine,
  input wire logic [DEF_IDX_W-1:0] i_key_default_idx,
  input wire logic [BLK_W-1:0] i_key_blocks,
  input wire logic i_match_hit,
  input wire logic [ADDR_W-1:0] i_match_addr,
  input wire logic i_map_req,
  input wire logic o_res_valid,
  input wire logic o_res_default,
  input wire logic [ADDR_W-1:0] o_res_addr,
  input wire logic o_cnt_inc,
  input wire logic [ADDR_W-1:0] o_cnt_addr,
  input wire logic o_map_ack
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  function automatic logic [15:0] dflt(input logic [1:0] e, input logic [6:0] n);
    logic [15:0] b;
    b = (e == 2'h0) ? CLS_A_DEF_BASE : (e == 2'h1) ? CLS_B_DEF_BASE : (e == 2'h2) ? CLS_C_DEF_BASE : ING2_DEF_BASE;
    return b + {5'h0, n, 4'h0};
  endfunction
  logic ok_idx;
  assign ok_idx = i_key_default_idx < ((i_key_engine == 2'h3) ? ING2_DEF_COUNT : CLS_DEF_COUNT);
  sequence key_miss; i_key_valid && ok_idx && (!i_match_hit || i_key_blocks == 4'h0); endsequence
  sequence key_hit; i_key_valid && i_match_hit && i_key_blocks != 4'h0; endsequence
  a_res_one_cycle: assert property (i_key_valid |=> o_res_valid && o_cnt_inc)
    else $error("no result after key");
  a_res_quiet: assert property (!i_key_valid |=> !o_res_valid && !o_cnt_inc) else $error("stray result");
  a_miss_default: assert property (key_miss |=> o_res_default &&
    o_res_addr == dflt($past(i_key_engine), $past(i_key_default_idx))) else $error("bad default addr");
  a_hit_match: assert property (key_hit |=> !o_res_default && o_res_addr == $past(i_match_addr))
    else $error("bad match addr");
  a_noblk_default: assert property (i_key_valid && i_key_blocks == 4'h0 |=> o_res_default)
    else $error("no default with no blocks");
  a_cnt_target: assert property (o_cnt_inc |-> o_cnt_addr == o_res_addr)
    else $error("counter addr differs");
  a_cnt_default: assert property (key_miss |=> o_cnt_inc &&
    o_cnt_addr == dflt($past(i_key_engine), $past(i_key_default_idx))) else $error("bad counter default addr");
  a_res_held: assert property (!i_key_valid |=> $stable(o_res_addr) && $stable(o_res_default))
    else $error("result not held");
  a_map_answer: assert property (i_map_req |=> o_map_ack) else $error("no map answer");
endmodule
`default_nettype wire

// ---- tcam_layout_pkg.sv ----
/*
  Shared constants for the rule layout and default-rule lookup of the
  classification and second ingress match engines.
  Assumes one switch core clock; imported whole by every design file.
*/
package tcam_layout_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BIT_W = 10;
  localparam int unsigned DEF_IDX_W = 7;
  localparam int unsigned BLK_W = 4;

  localparam logic [5:0] ENTRY_BITS = 6'd36;
  localparam logic [6:0] ACTION_BITS = 7'd70;
  localparam int unsigned ADDRS_PER_BLOCK = 4096;
  localparam int unsigned MAX_OFFSETS = 16;

  localparam logic [2:0] LG_X1 = 3'd0;
  localparam logic [2:0] LG_X4 = 3'd2;
  localparam logic [2:0] LG_X16 = 3'd4;

  localparam logic [ADDR_W-1:0] CLS_A_DEF_BASE = 16'd32768;
  localparam logic [ADDR_W-1:0] CLS_B_DEF_BASE = 16'd34592;
  localparam logic [ADDR_W-1:0] CLS_C_DEF_BASE = 16'd36416;
  localparam logic [ADDR_W-1:0] ING2_DEF_BASE = 16'd38240;
  localparam int unsigned DEF_STRIDE_LG = 4;
  localparam logic [DEF_IDX_W-1:0] CLS_DEF_COUNT = 7'd114;
  localparam logic [DEF_IDX_W-1:0] ING2_DEF_COUNT = 7'd58;

  typedef enum logic [1:0] {
    ENG_CLS_A = 2'b00,
    ENG_CLS_B = 2'b01,
    ENG_CLS_C = 2'b10,
    ENG_ING2 = 2'b11
  } engine_e;

endpackage

// ---- tcam_rule_layout_default_hit.sv ----
/*
  Lookup resolver and rule-layout query for the classification engine
  (three instances) and the second ingress engine. Picks the default rule in
  parallel with each key, falls back to it on a miss, and names the counter
  to bump. Assumes the match array answers in the same cycle as the key and
  that software keeps the tag, alignment and write-order duties.
*/
// How it works
// - classification bits packed across addresses after tags
// - default rule chosen alongside every submitted key
// - no blocks allocated means default rule hit
// - three instances, 114 defaults, first base 32768 stride 16
// - other instance bases 34592 and 36416, stride 16
// - second ingress: 4096 addresses/block, 36+70 bits, counter
// - second ingress entries X4/X8/X16, actions X4 only
// - second ingress bits packed, sixteen-address ends 568
// - second ingress has 58 defaults at 38240+16n
// - second ingress falls back to default on miss
// - matched rule bumps counter at its offset zero
`timescale 1ns/1ps
`default_nettype none
module tcam_rule_layout_default_hit
  import tcam_layout_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_key_valid,
  input wire logic [1:0] i_key_engine,
  input wire logic [DEF_IDX_W-1:0] i_key_default_idx,
  input wire logic [BLK_W-1:0] i_key_blocks,
  input wire logic i_match_hit,
  input wire logic [ADDR_W-1:0] i_match_addr,
  input wire logic i_map_req,
  input wire logic i_map_ing2,
  input wire logic [2:0] i_map_size_lg,
  input wire logic [3:0] i_map_offset,
  output logic o_res_valid,
  output logic o_res_default,
  output logic o_res_idx_err,
  output logic [ADDR_W-1:0] o_res_addr,
  output logic o_cnt_inc,
  output logic [ADDR_W-1:0] o_cnt_addr,
  output logic o_map_ack,
  output logic o_map_legal,
  output logic [2:0] o_map_tag_w,
  output logic [4:0] o_map_tag_v,
  output logic [BIT_W-1:0] o_map_e_lo,
  output logic [BIT_W-1:0] o_map_e_hi,
  output logic o_map_act_used,
  output logic [BIT_W-1:0] o_map_a_lo,
  output logic [BIT_W-1:0] o_map_a_hi
);

  typedef struct packed {
    logic res_valid;
    logic res_default;
    logic res_idx_err;
    logic [ADDR_W-1:0] res_addr;
    logic cnt_inc;
    logic [ADDR_W-1:0] cnt_addr;
    logic map_ack;
    logic map_legal;
    logic [2:0] tag_w;
    logic [4:0] tag_v;
    logic [BIT_W-1:0] e_lo;
    logic [BIT_W-1:0] e_hi;
    logic act_used;
    logic [BIT_W-1:0] a_lo;
    logic [BIT_W-1:0] a_hi;
  } state_s;

  state_s state_q;
  state_s state_d;

  layout_query_if lq ();

  assign lq.is_ing2 = i_map_ing2;
  assign lq.size_lg = i_map_size_lg;
  assign lq.offset = i_map_offset;

  rule_slice_map u_map (
    .q(lq)
  );

  engine_e eng;
  logic [ADDR_W-1:0] def_base;
  logic [DEF_IDX_W-1:0] def_count;
  logic [DEF_IDX_W-1:0] def_idx;
  logic [ADDR_W-1:0] def_addr;
  logic idx_bad;
  logic hit;

  always_comb begin
    eng = engine_e'(i_key_engine);
    def_base = CLS_A_DEF_BASE;
    def_count = CLS_DEF_COUNT;
    case (eng)
      ENG_CLS_A: begin
        def_base = CLS_A_DEF_BASE;
        def_count = CLS_DEF_COUNT;
      end
      ENG_CLS_B: begin
        def_base = CLS_B_DEF_BASE;
        def_count = CLS_DEF_COUNT;
      end
      ENG_CLS_C: begin
        def_base = CLS_C_DEF_BASE;
        def_count = CLS_DEF_COUNT;
      end
      ENG_ING2: begin
        def_base = ING2_DEF_BASE;
        def_count = ING2_DEF_COUNT;
      end
      default: begin
        def_base = CLS_A_DEF_BASE;
        def_count = CLS_DEF_COUNT;
      end
    endcase
    // Out-of-range index falls back to default rule zero rather than alias
    idx_bad = (i_key_default_idx >= def_count);
    def_idx = idx_bad ? '0 : i_key_default_idx;
    def_addr = def_base + ADDR_W'({def_idx, {DEF_STRIDE_LG{1'b0}}});
    // No blocks means the array cannot match, whatever it reports
    hit = i_match_hit && (i_key_blocks != '0);
  end

  always_comb begin
    state_d = state_q;
    state_d.res_valid = i_key_valid;
    state_d.cnt_inc = i_key_valid;
    if (i_key_valid) begin
      state_d.res_default = !hit;
      state_d.res_idx_err = idx_bad;
      state_d.res_addr = hit ? i_match_addr : def_addr;
      state_d.cnt_addr = hit ? i_match_addr : def_addr;
    end
    state_d.map_ack = i_map_req;
    if (i_map_req) begin
      state_d.map_legal = lq.legal;
      state_d.tag_w = lq.tag_w;
      state_d.tag_v = lq.tag_v;
      state_d.e_lo = lq.e_lo;
      state_d.e_hi = lq.e_hi;
      state_d.act_used = lq.act_used;
      state_d.a_lo = lq.a_lo;
      state_d.a_hi = lq.a_hi;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_res_valid = state_q.res_valid;
  assign o_res_default = state_q.res_default;
  assign o_res_idx_err = state_q.res_idx_err;
  assign o_res_addr = state_q.res_addr;
  assign o_cnt_inc = state_q.cnt_inc;
  assign o_cnt_addr = state_q.cnt_addr;
  assign o_map_ack = state_q.map_ack;
  assign o_map_legal = state_q.map_legal;
  assign o_map_tag_w = state_q.tag_w;
  assign o_map_tag_v = state_q.tag_v;
  assign o_map_e_lo = state_q.e_lo;
  assign o_map_e_hi = state_q.e_hi;
  assign o_map_act_used = state_q.act_used;
  assign o_map_a_lo = state_q.a_lo;
  assign o_map_a_hi = state_q.a_hi;

endmodule
`default_nettype wire
